// ==== src/osc_sel_pkg.sv ====
// Purpose: shared constants and types of the system clock source selector
// Assumes: 10 MHz sys_clk, 16-bit register port
// Notes: register indices are word indices on the plain register port
package osc_sel_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [3:0] OSC_CTRL_ADDR = 4'h0;
    localparam logic [3:0] IRQ_STATUS_ADDR = 4'h1;
    localparam logic [3:0] IRQ_MASK_ADDR = 4'h2;
    // oscillator_control field positions
    localparam int CUR_LSB = 12;
    localparam int NEW_LSB = 8;
    localparam int LOCK_BIT = 7;
    localparam int PIN_LOCK_BIT = 6;
    localparam int PLL_LOCK_BIT = 5;
    localparam int CF_BIT = 3;
    localparam int SEC_EN_BIT = 1;
    localparam int SW_REQ_BIT = 0;
    // interrupt status and mask bits
    localparam int IRQ_W = 3;
    localparam int IRQ_SWITCH_BIT = 0;
    localparam int IRQ_FAIL_BIT = 1;
    localparam int IRQ_PLL_BIT = 2;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    typedef enum logic [2:0] {
        SRC_FAST_RC = 3'h0,
        SRC_FAST_RC_PLL = 3'h1,
        SRC_PRIMARY = 3'h2,
        SRC_PRIMARY_PLL = 3'h3,
        SRC_SECONDARY = 3'h4,
        SRC_LOW_POWER_RC = 3'h5,
        SRC_FAST_RC_DIV16 = 3'h6,
        SRC_FAST_RC_DIV_N = 3'h7
    } src_t;
    localparam src_t ERASED_SOURCE = SRC_FAST_RC_DIV_N;
    typedef enum logic [1:0] {
        MODE_APPLIED = 2'h0,
        MODE_STANDARD = 2'h1,
        MODE_FAST = 2'h2,
        MODE_RESERVED = 2'h3
    } pmode_t;
    typedef enum logic [1:0] {
        ST_RUN = 2'h1,
        ST_SWITCH = 2'h2
    } state_t;
    localparam int unsigned FAST_RC_FIXED_DIV = 16;
    // timing
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned SWITCH_TIME_NS = 10000;
    localparam int unsigned SWITCH_CYCLES = (SWITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PLL_START_NS = 2000;
    localparam int unsigned PLL_START_CYCLES = (PLL_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W = 8;
endpackage

// ==== src/clk_sel_if.sv ====
// Purpose: carries a source code to the decoder and the decoded enables back
// Assumes: purely combinational path
// Notes: none
`timescale 1ns/1ps
interface clk_sel_if;
    logic [2:0] source;
    logic [1:0] mode;
    logic pin_fn;
    logic fast_rc_en;
    logic low_power_rc_en;
    logic secondary_sel;
    logic primary_en;
    logic pll_en;
    logic div16;
    logic div_n;
    logic fast_crystal;
    logic standard_crystal;
    logic applied_clk;
    logic osc2_io;
    modport dec(input source, mode, pin_fn, output fast_rc_en, low_power_rc_en,
        secondary_sel, primary_en, pll_en, div16, div_n, fast_crystal,
        standard_crystal, applied_clk, osc2_io);
    modport use_side(output source, mode, pin_fn, input fast_rc_en, low_power_rc_en,
        secondary_sel, primary_en, pll_en, div16, div_n, fast_crystal,
        standard_crystal, applied_clk, osc2_io);
endinterface

// ==== src/source_decode.sv ====
// Purpose: turns a three-bit source code and primary mode into source enables
// Assumes: inputs stable within a cycle
// Notes: combinational only
`timescale 1ns/1ps
module source_decode (
    clk_sel_if.dec sel
);
    wire is_primary;
    assign is_primary = (sel.source == osc_sel_pkg::SRC_PRIMARY)
        || (sel.source == osc_sel_pkg::SRC_PRIMARY_PLL);
    assign sel.fast_rc_en = (sel.source == osc_sel_pkg::SRC_FAST_RC)
        || (sel.source == osc_sel_pkg::SRC_FAST_RC_PLL)
        || (sel.source == osc_sel_pkg::SRC_FAST_RC_DIV16)
        || (sel.source == osc_sel_pkg::SRC_FAST_RC_DIV_N);
    assign sel.pll_en = (sel.source == osc_sel_pkg::SRC_FAST_RC_PLL)
        || (sel.source == osc_sel_pkg::SRC_PRIMARY_PLL);
    assign sel.low_power_rc_en = (sel.source == osc_sel_pkg::SRC_LOW_POWER_RC);
    assign sel.secondary_sel = (sel.source == osc_sel_pkg::SRC_SECONDARY);
    assign sel.div16 = (sel.source == osc_sel_pkg::SRC_FAST_RC_DIV16);
    assign sel.div_n = (sel.source == osc_sel_pkg::SRC_FAST_RC_DIV_N);
    assign sel.primary_en = is_primary;
    // mode only looked at for primary codes
    assign sel.fast_crystal = is_primary && (sel.mode == osc_sel_pkg::MODE_FAST);
    assign sel.standard_crystal = is_primary && (sel.mode == osc_sel_pkg::MODE_STANDARD);
    // reserved mode falls back to the applied clock, the safest pin setup
    assign sel.applied_clk = is_primary && ((sel.mode == osc_sel_pkg::MODE_APPLIED)
        || (sel.mode == osc_sel_pkg::MODE_RESERVED));
    assign sel.osc2_io = !(sel.fast_crystal || sel.standard_crystal) && sel.pin_fn;
endmodule

// ==== src/stage_timer.sv ====
// Purpose: counts cycles while run is high and flags when the count is reached
// Assumes: count fits in W bits
// Notes: done is a level that holds until run drops
`timescale 1ns/1ps
module stage_timer #(
    parameter int unsigned COUNT = 4,
    parameter int W = 8
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic run,
    output logic done
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    assign done = run && (cnt_reg == W'(COUNT));
    assign cnt_next = !run ? '0 : (done ? cnt_reg : cnt_reg + W'(1));
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule

// ==== src/osc_select_top.sv ====
// Purpose: power-on clock source selection and the oscillator control register
// Assumes: srst is the power-on reset; config inputs are stable around its release
// Notes: switch sequencing is a fixed settle delay, not a model of the sources
`timescale 1ns/1ps
module osc_select_top (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [2:0] initial_source_field,
    input wire logic [1:0] primary_mode_field,
    input wire logic osc_pin_function_select,
    input wire logic config_erased,
    input wire logic pll_locked,
    input wire logic clock_fail_detect,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic irq,
    output logic fast_rc_osc_en,
    output logic low_power_rc_osc_en,
    output logic secondary_osc_sel,
    output logic secondary_osc_en,
    output logic primary_osc_en,
    output logic pll_en,
    output logic fast_rc_div16,
    output logic fast_rc_div_n,
    output logic fast_crystal,
    output logic standard_crystal,
    output logic applied_clock_pin_mode,
    output logic osc2_pin_is_io,
    output logic pin_map_lock
);
    clk_sel_if sel ();

    source_decode u_decode (
        .sel(sel)
    );

    logic [2:0] current_reg;
    logic [2:0] new_reg;
    logic lock_reg;
    logic pin_lock_reg;
    logic cf_reg;
    logic sec_en_reg;
    logic sw_req_reg;
    logic pll_lock_reg;
    logic [2:0] irq_stat_reg;
    logic [2:0] irq_mask_reg;
    logic [15:0] rdata_reg;
    logic irq_reg;
    osc_sel_pkg::state_t state_reg;
    osc_sel_pkg::state_t state_next;

    logic fast_rc_reg;
    logic low_power_rc_osc_reg;
    logic secondary_osc_sel_reg;
    logic prim_reg;
    logic pll_reg;
    logic div16_reg;
    logic divn_reg;
    logic fxtal_reg;
    logic sxtal_reg;
    logic applied_reg;
    logic osc2_reg;
    logic sec_on_reg;

    wire [2:0] init_source;
    wire wr_ctrl;
    wire wr_mask;
    wire rd_stat;
    wire req_accept;
    wire switch_done;
    wire switch_complete;
    wire pll_timer_done;
    wire pll_lock_now;
    wire [2:0] events;
    wire [2:0] irq_stat_next;
    wire [2:0] irq_mask_next;
    wire [15:0] ctrl_word;
    wire [15:0] rd_word;
    wire cf_next;
    wire sec_en_next;

    // erased memory overrides whatever the source field reads
    assign init_source = config_erased ? 3'(osc_sel_pkg::ERASED_SOURCE)
        : initial_source_field;

    // decode always looks at the active source
    assign sel.source = current_reg;
    assign sel.mode = primary_mode_field;
    assign sel.pin_fn = osc_pin_function_select;

    assign wr_ctrl = reg_wr && (reg_addr == osc_sel_pkg::OSC_CTRL_ADDR);
    assign wr_mask = reg_wr && (reg_addr == osc_sel_pkg::IRQ_MASK_ADDR);
    assign rd_stat = reg_rd && (reg_addr == osc_sel_pkg::IRQ_STATUS_ADDR);

    // a locked clock ignores any switch request
    assign req_accept = wr_ctrl && reg_wdata[osc_sel_pkg::SW_REQ_BIT] && !lock_reg;

    stage_timer #(
        .COUNT(osc_sel_pkg::SWITCH_CYCLES),
        .W(osc_sel_pkg::TIMER_W)
    ) u_switch_timer (
        .sys_clk(sys_clk),
        .srst(srst),
        .run(state_reg == osc_sel_pkg::ST_SWITCH),
        .done(switch_done)
    );

    // start-up timer restarts on every switch, so a new pll source waits again
    stage_timer #(
        .COUNT(osc_sel_pkg::PLL_START_CYCLES),
        .W(osc_sel_pkg::TIMER_W)
    ) u_pll_timer (
        .sys_clk(sys_clk),
        .srst(srst),
        .run(sel.pll_en && (state_reg == osc_sel_pkg::ST_RUN)),
        .done(pll_timer_done)
    );

    assign pll_lock_now = sel.pll_en && (pll_locked || pll_timer_done);
    assign switch_complete = (state_reg == osc_sel_pkg::ST_SWITCH) && switch_done;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            osc_sel_pkg::ST_RUN: begin
                if (sw_req_reg) begin
                    state_next = osc_sel_pkg::ST_SWITCH;
                end
            end
            osc_sel_pkg::ST_SWITCH: begin
                if (switch_done) begin
                    state_next = osc_sel_pkg::ST_RUN;
                end
            end
            default: begin
                state_next = osc_sel_pkg::ST_RUN;
            end
        endcase
    end

    // new fail wins over a software clear in the same cycle
    assign cf_next = clock_fail_detect
        || (cf_reg && !(wr_ctrl && !reg_wdata[osc_sel_pkg::CF_BIT]));

    assign sec_en_next = wr_ctrl ? reg_wdata[osc_sel_pkg::SEC_EN_BIT] : sec_en_reg;

    assign events[osc_sel_pkg::IRQ_SWITCH_BIT] = switch_complete;
    assign events[osc_sel_pkg::IRQ_FAIL_BIT] = clock_fail_detect;
    assign events[osc_sel_pkg::IRQ_PLL_BIT] = pll_lock_now && !pll_lock_reg;
    // read clears, but a same-cycle event survives
    assign irq_stat_next = (rd_stat ? 3'h0 : irq_stat_reg) | events;
    assign irq_mask_next = wr_mask ? reg_wdata[osc_sel_pkg::IRQ_W-1:0] : irq_mask_reg;

    assign ctrl_word = {1'b0, current_reg, 1'b0, new_reg, lock_reg, pin_lock_reg,
        pll_lock_reg, 1'b0, cf_reg, 1'b0, sec_en_reg, sw_req_reg};
    assign rd_word = (reg_addr == osc_sel_pkg::OSC_CTRL_ADDR) ? ctrl_word
        : (reg_addr == osc_sel_pkg::IRQ_STATUS_ADDR) ? {13'h0000, irq_stat_reg}
        : (reg_addr == osc_sel_pkg::IRQ_MASK_ADDR) ? {13'h0000, irq_mask_reg}
        : 16'h0000;

    // control register
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            current_reg <= init_source;
            new_reg <= init_source;
            lock_reg <= 1'b0;
            pin_lock_reg <= 1'b0;
            sec_en_reg <= 1'b0;
            cf_reg <= 1'b0;
        end else begin
            if (switch_complete) begin
                current_reg <= new_reg;
            end
            if (wr_ctrl && !lock_reg && (state_reg == osc_sel_pkg::ST_RUN) && !sw_req_reg) begin
                new_reg <= reg_wdata[osc_sel_pkg::NEW_LSB +: 3];
            end
            if (wr_ctrl) begin
                // lock is set-only until the next power-on
                lock_reg <= lock_reg | reg_wdata[osc_sel_pkg::LOCK_BIT];
                pin_lock_reg <= reg_wdata[osc_sel_pkg::PIN_LOCK_BIT];
                sec_en_reg <= reg_wdata[osc_sel_pkg::SEC_EN_BIT];
            end
            cf_reg <= cf_next;
        end
    end

    // switch request and sequencing
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sw_req_reg <= 1'b0;
            state_reg <= osc_sel_pkg::ST_RUN;
        end else begin
            if (switch_complete) begin
                sw_req_reg <= 1'b0;
            end else if (req_accept) begin
                sw_req_reg <= 1'b1;
            end
            state_reg <= state_next;
        end
    end

    // status, interrupt and read port
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pll_lock_reg <= 1'b0;
            irq_stat_reg <= osc_sel_pkg::IRQ_RESET;
            irq_mask_reg <= osc_sel_pkg::IRQ_RESET;
            irq_reg <= 1'b0;
            rdata_reg <= 16'h0000;
        end else begin
            pll_lock_reg <= pll_lock_now;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            irq_reg <= |(irq_stat_next & irq_mask_next);
            rdata_reg <= reg_rd ? rd_word : 16'h0000;
        end
    end

    // source enables, registered so outputs never glitch during decode
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            fast_rc_reg <= 1'b0;
            low_power_rc_osc_reg <= 1'b0;
            secondary_osc_sel_reg <= 1'b0;
            prim_reg <= 1'b0;
            pll_reg <= 1'b0;
            div16_reg <= 1'b0;
            divn_reg <= 1'b0;
            fxtal_reg <= 1'b0;
            sxtal_reg <= 1'b0;
            applied_reg <= 1'b0;
            osc2_reg <= 1'b0;
            sec_on_reg <= 1'b0;
        end else begin
            fast_rc_reg <= sel.fast_rc_en;
            low_power_rc_osc_reg <= sel.low_power_rc_en;
            secondary_osc_sel_reg <= sel.secondary_sel;
            prim_reg <= sel.primary_en;
            pll_reg <= sel.pll_en;
            div16_reg <= sel.div16;
            divn_reg <= sel.div_n;
            fxtal_reg <= sel.fast_crystal;
            sxtal_reg <= sel.standard_crystal;
            applied_reg <= sel.applied_clk;
            osc2_reg <= sel.osc2_io;
            // secondary runs when enabled by software or when it is the clock
            sec_on_reg <= sec_en_next || sel.secondary_sel;
        end
    end

    assign reg_rdata = rdata_reg;
    assign irq = irq_reg;
    assign fast_rc_osc_en = fast_rc_reg;
    assign low_power_rc_osc_en = low_power_rc_osc_reg;
    assign secondary_osc_sel = secondary_osc_sel_reg;
    assign secondary_osc_en = sec_on_reg;
    assign primary_osc_en = prim_reg;
    assign pll_en = pll_reg;
    assign fast_rc_div16 = div16_reg;
    assign fast_rc_div_n = divn_reg;
    assign fast_crystal = fxtal_reg;
    assign standard_crystal = sxtal_reg;
    assign applied_clock_pin_mode = applied_reg;
    assign osc2_pin_is_io = osc2_reg;
    assign pin_map_lock = pin_lock_reg;
endmodule

// ==== testbench/osc_select_assertions.sv ====
// Purpose: port checks of the clock source selector
// Assumes: decoded outputs trail the current source by one cycle
// Notes: bound to osc_select_top
`timescale 1ns/1ps
module osc_select_assertions (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [1:0] primary_mode_field,
    input wire logic osc_pin_function_select,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic fast_rc_osc_en,
    input wire logic low_power_rc_osc_en,
    input wire logic secondary_osc_sel,
    input wire logic secondary_osc_en,
    input wire logic primary_osc_en,
    input wire logic pll_en,
    input wire logic fast_rc_div16,
    input wire logic fast_rc_div_n,
    input wire logic fast_crystal,
    input wire logic standard_crystal,
    input wire logic applied_clock_pin_mode,
    input wire logic osc2_pin_is_io
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    // first edge after release still shows reset zeros
    chk_one_source: assert property (!$past(srst) |-> $onehot({fast_rc_osc_en,
        low_power_rc_osc_en, secondary_osc_sel, primary_osc_en})) else $error("source not one-hot");
    chk_pll_source: assert property (pll_en |-> fast_rc_osc_en || primary_osc_en)
        else $error("pll without fast rc or primary");
    chk_fast_xtal: assert property (fast_crystal |-> primary_osc_en &&
        $past(primary_mode_field) == 2'h2) else $error("fast crystal wrong mode");
    chk_std_xtal: assert property (standard_crystal |-> primary_osc_en &&
        $past(primary_mode_field) == 2'h1) else $error("standard crystal wrong mode");
    chk_applied_pin: assert property (applied_clock_pin_mode |-> primary_osc_en &&
        $past(primary_mode_field) inside {2'h0, 2'h3}) else $error("applied clock wrong mode");
    chk_divider_only: assert property ((fast_rc_div16 || fast_rc_div_n) |->
        fast_rc_osc_en && !pll_en && !(fast_rc_div16 && fast_rc_div_n))
        else $error("divider decode wrong");
    chk_mode_ignored: assert property (!primary_osc_en |-> !(fast_crystal ||
        standard_crystal || applied_clock_pin_mode)) else $error("mode used off primary");
    chk_pin_function: assert property (!$past(srst) |-> osc2_pin_is_io ==
        ($past(osc_pin_function_select) && !fast_crystal && !standard_crystal))
        else $error("osc2 pin function wrong");
    chk_pll_lock_bit: assert property (reg_rd && reg_addr == 4'h0 && !pll_en
        |=> !reg_rdata[5]) else $error("pll lock set without pll");
    chk_sec_enable: assert property (reg_wr && reg_addr == 4'h0 && reg_wdata[1]
        |=> secondary_osc_en) else $error("secondary not enabled");
endmodule
bind osc_select_top osc_select_assertions osc_select_assertions_i (.sys_clk(sys_clk),
    .srst(srst), .primary_mode_field(primary_mode_field),
    .osc_pin_function_select(osc_pin_function_select), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fast_rc_osc_en(fast_rc_osc_en), .low_power_rc_osc_en(low_power_rc_osc_en),
    .secondary_osc_sel(secondary_osc_sel), .secondary_osc_en(secondary_osc_en),
    .primary_osc_en(primary_osc_en), .pll_en(pll_en), .fast_rc_div16(fast_rc_div16),
    .fast_rc_div_n(fast_rc_div_n), .fast_crystal(fast_crystal),
    .standard_crystal(standard_crystal), .applied_clock_pin_mode(applied_clock_pin_mode),
    .osc2_pin_is_io(osc2_pin_is_io));

// ==== testbench/osc_partner.sv ====
// Purpose: behavioural pll and clock monitor facing the selector
// Assumes: one sys_clk domain
// Notes: lock_stall keeps the pll unlocked so the start-up timer path is used
`timescale 1ns/1ps
module osc_partner #(
    parameter int LOCK_CYCLES = 6
) (
    input wire logic sys_clk,
    input wire logic pll_en,
    input wire logic lock_stall,
    input wire logic fail_cmd,
    output logic pll_locked,
    output logic clock_fail_detect
);
    logic [7:0] cnt = 8'h0;
    initial pll_locked = 1'b0;
    initial clock_fail_detect = 1'b0;
    always @(posedge sys_clk) begin
        cnt <= pll_en ? ((cnt < 8'hff) ? cnt + 8'h1 : cnt) : 8'h0;
        pll_locked <= pll_en && !lock_stall && (cnt >= LOCK_CYCLES);
        clock_fail_detect <= fail_cmd;
    end
endmodule

// ==== testbench/testbench.sv ====
// Purpose: self-checking bench of the clock source selector
// Assumes: 10 MHz sys_clk, synchronous reset
// Notes: every scenario starts from its own power-on reset
`timescale 1ns/1ps
module testbench;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [2:0] init_src = 3'h0;
    logic [1:0] pmode = 2'h0;
    logic pin_fn = 1'b0;
    logic erased = 1'b0;
    logic stall = 1'b0;
    logic fail_cmd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] rd_val = 16'h0;
    wire [15:0] reg_rdata;
    wire [10:0] dec;
    wire pll_locked, clock_fail_detect, irq, sec_en, pin_lock;
    int failures = 0;
    int n_checks = 0;
    int cycles = 0;
    always #50 sys_clk = ~sys_clk;
    osc_select_top osc_select_top_i (.sys_clk(sys_clk), .srst(srst),
        .initial_source_field(init_src), .primary_mode_field(pmode),
        .osc_pin_function_select(pin_fn), .config_erased(erased), .pll_locked(pll_locked),
        .clock_fail_detect(clock_fail_detect), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .fast_rc_osc_en(dec[10]), .low_power_rc_osc_en(dec[9]), .secondary_osc_sel(dec[8]),
        .secondary_osc_en(sec_en), .primary_osc_en(dec[7]), .pll_en(dec[6]),
        .fast_rc_div16(dec[5]), .fast_rc_div_n(dec[4]), .fast_crystal(dec[3]),
        .standard_crystal(dec[2]), .applied_clock_pin_mode(dec[1]), .osc2_pin_is_io(dec[0]),
        .pin_map_lock(pin_lock));
    osc_partner osc_partner_i (.sys_clk(sys_clk), .pll_en(dec[6]), .lock_stall(stall),
        .fail_cmd(fail_cmd), .pll_locked(pll_locked), .clock_fail_detect(clock_fail_detect));
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask
    task automatic por(input logic [2:0] c, input logic [1:0] m, input logic p, input logic e);
        @(posedge sys_clk);
        init_src <= c;
        pmode <= m;
        pin_fn <= p;
        erased <= e;
        srst <= 1'b1;
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask
    function automatic logic [15:0] exp_dec(input logic [2:0] c, input logic [1:0] m,
        input logic p);
        logic prim, fx, sx;
        prim = (c == 3'h2) || (c == 3'h3);
        fx = prim && (m == 2'h2);
        sx = prim && (m == 2'h1);
        return {5'h0, c inside {3'h0, 3'h1, 3'h6, 3'h7}, c == 3'h5, c == 3'h4, prim,
            (c == 3'h1) || (c == 3'h3), c == 3'h6, c == 3'h7, fx, sx, prim && !fx && !sx,
            p && !fx && !sx};
    endfunction
    task automatic t_power_on();
        logic [15:0] e;
        for (int i = 0; i < 32; i++) begin
            por(i[4:2], i[1:0], i[0], 1'b0);
            e = exp_dec(i[4:2], i[1:0], i[0]);
            #1 chk("source", {5'h0, dec} & 16'h07f0, e & 16'h07f0);
            chk("mode", {5'h0, dec} & 16'h000f, e & 16'h000f);
            rd(4'h0);
            chk("fields", {8'h0, rd_val[15:8]}, {9'h0, i[4:2], 1'b0, i[4:2]});
        end
        por(3'h0, 2'h2, 1'b1, 1'b1);
        #1 chk("erased", {5'h0, dec}, exp_dec(3'h7, 2'h2, 1'b1));
    endtask
    task automatic t_switch();
        int n;
        por(3'h0, 2'h1, 1'b0, 1'b0);
        stall <= 1'b1;
        wr(4'h2, 16'h0001);
        wr(4'h0, 16'h0301);
        rd(4'h0);
        chk("pending", rd_val, 16'h0301);
        n = 0;
        // look after the edge has settled, or irq shows one cycle late
        while (irq !== 1'b1 && n < 300) begin
            @(posedge sys_clk);
            #1 n++;
        end
        chk("switch time", n[15:0], 16'(osc_sel_pkg::SWITCH_CYCLES));
        rd(4'h0);
        chk("switched", rd_val & 16'h7701, 16'h3300);
        chk("new decode", {5'h0, dec}, exp_dec(3'h3, 2'h1, 1'b0));
        rd(4'h1);
        chk("status", rd_val, 16'h0001);
        rd(4'h1);
        chk("status cleared", rd_val, 16'h0000);
        chk("irq low", {15'h0, irq}, 16'h0000);
        // pll held unlocked, so only the start-up timer can set the bit
        repeat (30) @(posedge sys_clk);
        rd(4'h0);
        chk("pll lock", rd_val & 16'h0020, 16'h0020);
        rd(4'h1);
        chk("pll status", rd_val, 16'h0004);
        stall <= 1'b0;
    endtask
    task automatic t_fail();
        por(3'h5, 2'h0, 1'b0, 1'b0);
        fail_cmd <= 1'b1;
        @(posedge sys_clk);
        fail_cmd <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 chk("masked irq", {15'h0, irq}, 16'h0000);
        wr(4'h0, 16'h050a);
        rd(4'h0);
        chk("fail kept", rd_val & 16'h000a, 16'h000a);
        chk("sec on", {15'h0, sec_en}, 16'h0001);
        wr(4'h0, 16'h0500);
        rd(4'h0);
        chk("fail cleared", rd_val & 16'h000a, 16'h0000);
        chk("sec off", {15'h0, sec_en}, 16'h0000);
        wr(4'h2, 16'h0002);
        #1 chk("fail irq", {15'h0, irq}, 16'h0001);
        rd(4'h1);
        chk("fail status", rd_val, 16'h0002);
        rd(4'hf);
        chk("unmapped", rd_val, 16'h0000);
    endtask
    task automatic t_lock();
        por(3'h0, 2'h0, 1'b0, 1'b0);
        wr(4'h0, 16'h00c0);
        #1 chk("pin lock", {15'h0, pin_lock}, 16'h0001);
        wr(4'h0, 16'h0501);
        repeat (110) @(posedge sys_clk);
        rd(4'h0);
        chk("locked", rd_val & 16'h7781, 16'h0080);
        chk("locked decode", {5'h0, dec}, exp_dec(3'h0, 2'h0, 1'b0));
        chk("pin free", {15'h0, pin_lock}, 16'h0000);
    endtask
    // a read twelve cycles after release tells the lock input from the start-up timer
    task automatic t_pll();
        stall <= 1'b1;
        por(3'h1, 2'h0, 1'b0, 1'b0);
        repeat (8) @(posedge sys_clk);
        rd(4'h0);
        chk("pll waiting", rd_val & 16'h0020, 16'h0000);
        stall <= 1'b0;
        por(3'h1, 2'h0, 1'b0, 1'b0);
        repeat (8) @(posedge sys_clk);
        rd(4'h0);
        chk("pll locked", rd_val & 16'h0020, 16'h0020);
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // whole run is about 900 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            end_of_test();
        end
    end
    initial begin
        por(3'h0, 2'h0, 1'b0, 1'b0);
        t_power_on();
        t_switch();
        t_fail();
        t_lock();
        t_pll();
        end_of_test();
    end
endmodule
